//--- logic/mcr_pkg.sv
// How it works
// - Reset command at 1A clears both registers
// - Power-on reset gives the same cleared state
// - Direct mode, reset pin low holds cleared state
// - General bit 6 one divides LO by two
// - General bit 4 enables bias supplies
// - General bit 0 enables the modulator
// - Address EB reads back general control
// - Transmitter bits 3..0 hold LO path setting
// - Address EE reads back transmitter control
// - Disable pin low selects direct pin control
// - Direct reset pin high leaves low power
// - Direct divider pin sets inverse of bit 6
// - Direct mode, reset pin high, forces bias and modulator on
// - Direct frequency pins map to path setting
// - Transaction is address byte, optional data byte
// - Command data sampled on serial clock rise
// - Each address is read-only or write-only
package mcr_pkg;

  localparam logic [7:0] ADDR_RESET = 8'h1A;
  localparam logic [7:0] ADDR_GEN = 8'h1B;
  localparam logic [7:0] ADDR_TX = 8'h1E;
  localparam logic [7:0] ADDR_GEN_RB = 8'hEB;
  localparam logic [7:0] ADDR_TX_RB = 8'hEE;

  localparam int GEN_DIV_BIT = 6;
  localparam int GEN_BIAS_BIT = 4;
  localparam int GEN_MOD_BIT = 0;
  localparam int TX_PATH_LSB = 0;
  localparam int TX_PATH_W = 4;

  localparam logic [7:0] GEN_RESET = 8'h00;
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic [7:0] GEN_POWER_MASK = 8'h11;
  localparam logic [7:0] GEN_DIRECT_BASE = 8'h11;
  localparam logic [7:0] TX_DIRECT_BASE = 8'h70;

  localparam logic [3:0] PATH_F00 = 4'h0;
  localparam logic [3:0] PATH_F10 = 4'h5;
  localparam logic [3:0] PATH_F01 = 4'hA;
  localparam logic [3:0] PATH_F11 = 4'hF;

  localparam int PIN_COUNT = 5;
  localparam logic [4:0] PIN_RESET = 5'h05;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_READ = 5'h08,
    ST_DONE = 5'h10
  } mcr_state_e;

  typedef struct packed {
    logic serial_clk_pin;
    logic command_data_in;
    logic chip_select_n;
    logic read_data_pin;
    logic serial_disable_n;
  } mcr_pins_s;

  typedef struct packed {
    logic lo_divider_select;
    logic bias_enable;
    logic modulator_enable;
    logic [3:0] lo_path_setting;
    logic powersave;
  } mcr_ctrl_s;

endpackage

//--- logic/mcr_sync.sv
`timescale 1ns/1ps
module mcr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] next_level;

  // A change counts only once the two later stages agree
  assign agree = ~(stage2 ^ stage3);
  assign next_level = (stage3 & agree) | (level & ~agree);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      meta <= async_in;
      stage2 <= meta;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  a_sync_agree_only:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (level != $past(level)) |-> (($past(stage2) ^ $past(stage3)) & (level ^ $past(level))) == '0)
    else $error("Synchronised level moved without agreement");

endmodule // mcr_sync

//--- logic/mcr_regs.sv
`timescale 1ns/1ps
module mcr_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire mcr_pkg::mcr_pins_s pins,
  output logic read_data_out,
  output logic read_data_oe,
  output logic direct_mode,
  output logic [7:0] general_control,
  output logic [7:0] transmitter_control,
  output mcr_pkg::mcr_ctrl_s ctrl
);

  // Filtered pins
  mcr_pkg::mcr_pins_s pins_f;

  mcr_sync #(
    .WIDTH(mcr_pkg::PIN_COUNT),
    .RESET_VAL(mcr_pkg::PIN_RESET)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pins),
    .level(pins_f)
  );

  // Serial side state
  mcr_pkg::mcr_state_e state;
  mcr_pkg::mcr_state_e next_state;
  logic sclk_d;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] in_shift;
  logic [7:0] next_in_shift;
  logic [7:0] read_shift;
  logic [7:0] next_read_shift;
  logic target_tx;
  logic next_target_tx;
  logic [7:0] next_general;
  logic [7:0] next_transmitter;
  logic por_seen;

  // Pin roles change with the mode
  wire direct = ~pins_f.serial_disable_n;
  wire serial_clk = pins_f.serial_clk_pin;
  wire serial_data = pins_f.command_data_in;
  wire select_high = pins_f.chip_select_n;
  wire direct_reset_n = pins_f.serial_clk_pin;
  wire direct_freq_bit1 = pins_f.command_data_in;
  wire direct_freq_bit2 = pins_f.chip_select_n;
  wire direct_divider_pin = pins_f.read_data_pin;

  // Edge of the filtered clock; a few core cycles late, which the host timing covers
  wire sclk_rise = serial_clk & ~sclk_d;
  wire last_bit = (bit_cnt == mcr_pkg::LAST_BIT);
  wire [7:0] rx_byte = {in_shift[6:0], serial_data};

  // Address decoding
  wire addr_done = (state == mcr_pkg::ST_ADDR) && sclk_rise && last_bit;
  wire hit_reset = (rx_byte == mcr_pkg::ADDR_RESET);
  wire hit_gen = (rx_byte == mcr_pkg::ADDR_GEN);
  wire hit_tx = (rx_byte == mcr_pkg::ADDR_TX);
  wire hit_gen_rb = (rx_byte == mcr_pkg::ADDR_GEN_RB);
  wire hit_tx_rb = (rx_byte == mcr_pkg::ADDR_TX_RB);
  wire hit_write = hit_gen || hit_tx;
  wire hit_read = hit_gen_rb || hit_tx_rb;
  wire reset_cmd = addr_done && hit_reset;
  wire data_done = (state == mcr_pkg::ST_DATA) && sclk_rise && last_bit;
  wire write_gen = data_done && !target_tx;
  wire write_tx = data_done && target_tx;
  wire [7:0] mirror_byte = hit_tx_rb ? transmitter_control : general_control;

  // Direct mode register images
  wire [3:0] direct_path =
    (direct_freq_bit1 && direct_freq_bit2) ? mcr_pkg::PATH_F11 :
    direct_freq_bit2 ? mcr_pkg::PATH_F01 :
    direct_freq_bit1 ? mcr_pkg::PATH_F10 :
    mcr_pkg::PATH_F00;
  wire [7:0] direct_gen = mcr_pkg::GEN_DIRECT_BASE | {1'b0, ~direct_divider_pin, 6'h00};
  wire [7:0] direct_tx = mcr_pkg::TX_DIRECT_BASE | {4'h0, direct_path};

  // Transaction sequencing
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_in_shift = in_shift;
    next_read_shift = read_shift;
    next_target_tx = target_tx;
    if (direct || select_high) begin
      next_state = mcr_pkg::ST_IDLE;
      next_bit_cnt = 3'h0;
    end else begin
      case (state)
        mcr_pkg::ST_IDLE: begin
          next_state = mcr_pkg::ST_ADDR;
          next_bit_cnt = 3'h0;
        end
        mcr_pkg::ST_ADDR: begin
          if (sclk_rise) begin
            next_in_shift = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (last_bit) begin
              if (hit_write) begin
                next_state = mcr_pkg::ST_DATA;
                next_target_tx = hit_tx;
              end else if (hit_read) begin
                next_state = mcr_pkg::ST_READ;
                next_read_shift = mirror_byte;
              end else begin
                next_state = mcr_pkg::ST_DONE;
              end
            end
          end
        end
        mcr_pkg::ST_DATA: begin
          if (sclk_rise) begin
            next_in_shift = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (last_bit) begin
              next_state = mcr_pkg::ST_DONE;
            end
          end
        end
        mcr_pkg::ST_READ: begin
          if (sclk_rise) begin
            next_read_shift = {read_shift[6:0], 1'b0};
            next_bit_cnt = bit_cnt + 3'h1;
            if (last_bit) begin
              next_state = mcr_pkg::ST_DONE;
            end
          end
        end
        mcr_pkg::ST_DONE: begin
          // Extra clocks are ignored until select goes high
          next_state = mcr_pkg::ST_DONE;
        end
        default: begin
          next_state = mcr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register update; direct mode overrides the serial path completely
  always_comb begin
    next_general = general_control;
    next_transmitter = transmitter_control;
    if (direct) begin
      if (!direct_reset_n) begin
        next_general = mcr_pkg::GEN_RESET;
        next_transmitter = mcr_pkg::TX_RESET;
      end else begin
        next_general = direct_gen;
        next_transmitter = direct_tx;
      end
    end else if (reset_cmd) begin
      next_general = mcr_pkg::GEN_RESET;
      next_transmitter = mcr_pkg::TX_RESET;
    end else if (write_gen) begin
      next_general = rx_byte;
    end else if (write_tx) begin
      next_transmitter = rx_byte;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= mcr_pkg::ST_IDLE;
      sclk_d <= 1'b0;
      bit_cnt <= 3'h0;
      in_shift <= 8'h00;
      read_shift <= 8'h00;
      target_tx <= 1'b0;
      general_control <= mcr_pkg::GEN_RESET;
      transmitter_control <= mcr_pkg::TX_RESET;
      por_seen <= 1'b0;
    end else begin
      state <= next_state;
      sclk_d <= serial_clk;
      bit_cnt <= next_bit_cnt;
      in_shift <= next_in_shift;
      read_shift <= next_read_shift;
      target_tx <= next_target_tx;
      general_control <= next_general;
      transmitter_control <= next_transmitter;
      por_seen <= 1'b1;
    end
  end

  // Outputs; read pin becomes an input in direct mode
  assign direct_mode = direct;
  assign read_data_out = read_shift[7];
  assign read_data_oe = (state == mcr_pkg::ST_READ) && !direct;
  assign ctrl.lo_divider_select = general_control[mcr_pkg::GEN_DIV_BIT];
  assign ctrl.bias_enable = general_control[mcr_pkg::GEN_BIAS_BIT];
  assign ctrl.modulator_enable = general_control[mcr_pkg::GEN_MOD_BIT];
  assign ctrl.lo_path_setting =
    transmitter_control[mcr_pkg::TX_PATH_LSB +: mcr_pkg::TX_PATH_W];
  assign ctrl.powersave = (general_control & mcr_pkg::GEN_POWER_MASK) == 8'h00;

  a_reset_cmd_clears:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (addr_done && hit_reset && !direct)
      |=> (general_control == mcr_pkg::GEN_RESET)
          && (transmitter_control == mcr_pkg::TX_RESET) && ctrl.powersave)
    else $error("Reset command did not clear registers");

  a_por_state:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !por_seen |-> (general_control == mcr_pkg::GEN_RESET)
                    && (transmitter_control == mcr_pkg::TX_RESET))
    else $error("Power-on state not cleared");

  a_direct_hold_reset:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (direct && !direct_reset_n) [*2]
      |-> (general_control == mcr_pkg::GEN_RESET)
          && (transmitter_control == mcr_pkg::TX_RESET) && ctrl.powersave)
    else $error("Direct reset pin low did not hold cleared state");

  a_gen_write_fields:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (write_gen && !direct)
      |=> (general_control == $past(rx_byte))
          && (ctrl.lo_divider_select == $past(rx_byte[6]))
          && (ctrl.bias_enable == $past(rx_byte[4]))
          && (ctrl.modulator_enable == $past(rx_byte[0])))
    else $error("General control write not applied");

  a_tx_write_path:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (write_tx && !direct)
      |=> (transmitter_control == $past(rx_byte))
          && (ctrl.lo_path_setting == $past(rx_byte[3:0])))
    else $error("Transmitter control write not applied");

  a_gen_readback:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (addr_done && hit_gen_rb && !direct)
      |=> (read_shift == $past(general_control)) && read_data_oe)
    else $error("General readback not loaded");

  a_tx_readback:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (addr_done && hit_tx_rb && !direct)
      |=> (read_shift == $past(transmitter_control)) && read_data_oe)
    else $error("Transmitter readback not loaded");

  a_direct_pins_take:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      direct |-> !read_data_oe && (state == mcr_pkg::ST_IDLE || !$past(direct)))
    else $error("Serial port active in direct mode");

  a_direct_active:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (direct && direct_reset_n) [*2]
      |-> !ctrl.powersave && ctrl.bias_enable && ctrl.modulator_enable
          && (general_control[7] == 1'b0) && (general_control[5] == 1'b0)
          && (general_control[3:1] == 3'h0))
    else $error("Direct mode general control image wrong");

  a_direct_divider:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (direct && direct_reset_n) |=> ctrl.lo_divider_select == !$past(direct_divider_pin))
    else $error("Direct divider pin not inverted into bit 6");

  a_direct_path_map:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (direct && direct_reset_n)
      |=> (transmitter_control[7:4] == 4'h7)
          && (transmitter_control[3:0] ==
              {$past(direct_freq_bit2), $past(direct_freq_bit1),
               $past(direct_freq_bit2), $past(direct_freq_bit1)}))
    else $error("Direct frequency pins mapped wrongly");

  a_select_abort:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (select_high && !direct) |=> (state == mcr_pkg::ST_IDLE) && !read_data_oe)
    else $error("Select high did not end the transaction");

  a_shift_on_rise:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !sclk_rise |=> $stable(in_shift))
    else $error("Command data sampled off a rising serial clock");

  a_write_addr_no_read:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (addr_done && hit_write && !direct)
      |=> (state == mcr_pkg::ST_DATA) ##1 !read_data_oe)
    else $error("Write address opened a read");

  a_read_msb_first:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      ((state == mcr_pkg::ST_READ) && sclk_rise && !select_high && !direct)
      |=> read_data_out == $past(read_shift[6]))
    else $error("Readback not shifted MSB first");

  a_select_opens_addr:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      ((state == mcr_pkg::ST_IDLE) && !select_high && !direct)
      |=> (state == mcr_pkg::ST_ADDR) && (bit_cnt == 3'h0))
    else $error("Select low did not open the address byte");

  a_count_on_rise:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (!sclk_rise && !select_high && !direct && (state != mcr_pkg::ST_IDLE))
      |=> $stable(bit_cnt))
    else $error("Bit count moved without a rising serial clock");

  a_unmapped_ignored:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (addr_done && !hit_write && !hit_read && !hit_reset && !direct)
      |=> (state == mcr_pkg::ST_DONE)
          && $stable(general_control) && $stable(transmitter_control))
    else $error("Unmapped address changed the registers");

  a_done_holds:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      ((state == mcr_pkg::ST_DONE) && !direct)
      |=> $stable(general_control) && $stable(transmitter_control))
    else $error("Registers changed after the transaction ended");

  a_read_no_write:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      ((state == mcr_pkg::ST_READ) && !direct)
      |=> $stable(general_control) && $stable(transmitter_control))
    else $error("Readback changed a register");

  a_read_ends:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      ((state == mcr_pkg::ST_READ) && sclk_rise && last_bit && !select_high && !direct)
      |=> (state == mcr_pkg::ST_DONE) && !read_data_oe)
    else $error("Readback did not stop after eight bits");

  a_gen_write_only:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (write_gen && !direct)
      |=> $stable(transmitter_control))
    else $error("General control write disturbed transmitter control");

  a_tx_write_only:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (write_tx && !direct)
      |=> $stable(general_control))
    else $error("Transmitter control write disturbed general control");

endmodule // mcr_regs

//--- bench/mcr_host.sv
`timescale 1ns/1ps
module mcr_host (
  input wire logic core_clk,
  input wire logic rd,
  output logic sclk,
  output logic sdata,
  output logic chip_select_n
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    chip_select_n = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Address byte then nbits-8 more clocks; readback bits are taken just before each rise
  task automatic xfer(input logic [7:0] addr, input logic [7:0] data, input int nbits,
                      output logic [7:0] rb);
    logic [15:0] word;
    word = {addr, data};
    if (addr == mcr_pkg::ADDR_GEN) word[7:0] = data & 8'h51;
    if (addr == mcr_pkg::ADDR_TX) word[7:0] = data & 8'h0F;
    rb = 8'h00;
    chip_select_n = 1'b0;
    wait_n(6);
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      sdata = word[15 - i];
      wait_n(6);
      if (i >= 8) rb = {rb[6:0], rd};
      sclk = 1'b1;
      wait_n(6);
    end
    sclk = 1'b0;
    chip_select_n = 1'b1;
    // Released data line must not keep looking valid
    sdata = ~sdata;
    wait_n(8);
  endtask
endmodule // mcr_host

//--- bench/modulator_control_regs_tb.sv
`timescale 1ns/1ps
module modulator_control_regs_tb;
  logic core_clk;
  logic rst_n;
  logic sdis_n, d_rst_n, d_f1, d_f2, d_div;
  logic h_sclk, h_sdata, h_select_n;
  logic rd_wire;
  mcr_pkg::mcr_pins_s pins;
  logic read_data_out, read_data_oe, direct_mode;
  logic [7:0] general_control, transmitter_control;
  mcr_pkg::mcr_ctrl_s ctrl;
  int n_errors = 0;
  int total_checks = 0;
  logic [7:0] rb, g, t;

  // Shared pins: direct-mode levels replace the host's when the bus is disabled
  // Undriven read line shows the inverse, so a missing drive spoils the readback
  assign rd_wire = read_data_oe ? read_data_out : (sdis_n ? ~read_data_out : d_div);
  assign pins = {sdis_n ? h_sclk : d_rst_n, sdis_n ? h_sdata : d_f1,
                 sdis_n ? h_select_n : d_f2, rd_wire, sdis_n};

  mcr_host host (.core_clk(core_clk), .rd(rd_wire), .sclk(h_sclk), .sdata(h_sdata),
                 .chip_select_n(h_select_n));
  mcr_regs dut (.core_clk(core_clk), .rst_n(rst_n), .pins(pins),
                .read_data_out(read_data_out), .read_data_oe(read_data_oe),
                .direct_mode(direct_mode), .general_control(general_control),
                .transmitter_control(transmitter_control), .ctrl(ctrl));

  always #2 core_clk = ~core_clk;

  function automatic logic [7:0] exp_ctrl(input logic [7:0] gv, input logic [7:0] tv);
    mcr_pkg::mcr_ctrl_s c;
    c.lo_divider_select = gv[6];
    c.bias_enable = gv[4];
    c.modulator_enable = gv[0];
    c.lo_path_setting = tv[3:0];
    c.powersave = ~gv[4] & ~gv[0];
    return c;
  endfunction

  function automatic logic [3:0] exp_path(input logic f1, input logic f2);
    case ({f1, f2})
      2'b00: return 4'h0;
      2'b10: return 4'h5;
      2'b01: return 4'hA;
      default: return 4'hF;
    endcase
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_regs(input logic [7:0] gv, input logic [7:0] tv);
    check("general_control", general_control, gv);
    check("transmitter_control", transmitter_control, tv);
    check("ctrl", ctrl, exp_ctrl(gv, tv));
  endtask

  task automatic read_back(input logic [7:0] gv, input logic [7:0] tv);
    host.xfer(mcr_pkg::ADDR_GEN_RB, 8'h00, 16, rb);
    check("general_readback", rb, gv);
    host.xfer(mcr_pkg::ADDR_TX_RB, 8'h00, 16, rb);
    check("transmitter_readback", rb, tv);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    final_report();
  end

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    sdis_n = 1'b1;
    d_rst_n = 1'b1;
    {d_div, d_f1, d_f2} = 3'h0;
    void'($urandom(32'h28A5));
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    check_regs(8'h00, 8'h00);
    read_back(8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      g = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      t = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      host.xfer(mcr_pkg::ADDR_GEN, g, 16, rb);
      host.xfer(mcr_pkg::ADDR_TX, t, 16, rb);
      g &= 8'h51;
      t &= 8'h0F;
      check_regs(g, t);
      read_back(g, t);
    end
    host.xfer(mcr_pkg::ADDR_GEN, 8'h51, 16, rb);
    host.xfer(mcr_pkg::ADDR_TX, 8'h0F, 16, rb);
    // Data aimed at readback or unmapped addresses must not land
    host.xfer(mcr_pkg::ADDR_GEN_RB, 8'h00, 16, rb);
    check("readback_write", rb, 8'h51);
    host.xfer(8'h55, 8'hFF, 16, rb);
    check_regs(8'h51, 8'h0F);
    // Select raised in the middle of the data byte: nothing may land
    host.xfer(mcr_pkg::ADDR_GEN, 8'h00, 12, rb);
    check_regs(8'h51, 8'h0F);
    host.xfer(mcr_pkg::ADDR_RESET, 8'h00, 8, rb);
    check_regs(8'h00, 8'h00);
    sdis_n = 1'b0;
    for (int k = 0; k < 9; k++) begin
      d_rst_n = (k != 4);
      {d_div, d_f1, d_f2} = 3'(k);
      repeat (12) @(negedge core_clk);
      check("direct_mode", {7'h00, direct_mode}, 8'h01);
      if (k == 4) begin
        check_regs(8'h00, 8'h00);
      end else begin
        check_regs({1'b0, ~d_div, 6'h11}, {4'h7, exp_path(d_f1, d_f2)});
      end
    end
    sdis_n = 1'b1;
    repeat (12) @(negedge core_clk);
    check("direct_mode", {7'h00, direct_mode}, 8'h00);
    host.xfer(mcr_pkg::ADDR_GEN, 8'h40, 16, rb);
    host.xfer(mcr_pkg::ADDR_TX, 8'h0A, 16, rb);
    check_regs(8'h40, 8'h0A);
    read_back(8'h40, 8'h0A);
    // Power-on reset again in mid-run, with both registers holding ones
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    check_regs(8'h00, 8'h00);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    check_regs(8'h00, 8'h00);
    read_back(8'h00, 8'h00);
    final_report();
  end
endmodule // modulator_control_regs_tb
